/* File: hdl/throttle_pkg.sv */
// Purpose: Shared constants and state layout for the bandwidth throttle
// Assumes: 32-bit AXI4-Lite register access, 64-bit controls as two words
// Notes: Field positions follow the 64-bit control layout
package throttle_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_WCTL_LO = 8'h50;
  localparam logic [7:0] OFF_WCTL_HI = 8'h54;
  localparam logic [7:0] OFF_RCTL_LO = 8'h58;
  localparam logic [7:0] OFF_RCTL_HI = 8'h5c;
  localparam logic [7:0] OFF_STAT = 8'h60;
  localparam logic [7:0] OFF_LOCK = 8'h64;

  // Control reset value and writable bits (63:49 reserved, read as zero)
  localparam logic [63:0] CTL_RESET = 64'h0000_0000_0000_0000;
  localparam logic [63:0] CTL_MASK = 64'h0001_ffff_ffff_ffff;

  // Field positions; window and threshold fields shared by write and read controls, the rest write only
  localparam int GSW_LSB = 41;
  localparam int GSW_MSB = 48;
  localparam int GHT_LSB = 28;
  localparam int GHT_MSB = 40;
  localparam int DUR_LSB = 22;
  localparam int DUR_MSB = 27;
  localparam int MW_LSB = 15;
  localparam int MW_MSB = 21;
  localparam int HM_LSB = 3;
  localparam int HM_MSB = 14;
  localparam int MODE_LSB = 1;
  localparam int MODE_MSB = 2;
  localparam int SW_START_BIT = 0;

  // Write limit mode encodings
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_HW = 2'h1;
  localparam logic [1:0] MODE_CNT = 2'h2;

  // Scale factors: host clocks per window unit, hexwords per threshold unit
  localparam int SAMPLE_UNIT_CLKS = 400000;
  localparam int HEXWORD_UNIT = 32768;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SEL_WLO, SEL_WHI, SEL_RLO, SEL_RHI, SEL_STAT, SEL_LOCK, SEL_NONE
  } reg_sel_t;

  typedef struct packed {
    logic [63:0] wctl;
    logic [63:0] rctl;
    logic lock;
    logic hot_s1;
    logic hot_s2;
    logic [31:0] wg_cnt;
    logic [31:0] wg_hex;
    logic [5:0] wdur;
    logic [10:0] wm_cnt;
    logic [11:0] wm_hex;
    logic wact;
    logic wblk;
    logic [31:0] rg_cnt;
    logic [31:0] rg_hex;
    logic rover;
    logic aw_hold;
    logic w_hold;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

endpackage

/* File: hdl/dram_bandwidth_throttle.sv */
// Purpose: Write and read bandwidth throttle with AXI4-Lite registers
// Assumes: Scheduler pulses one hexword per cycle on each counting input
// Notes: Controls are 64-bit, reached as two 32-bit words
// Function
// R1: Mode 01 enables thermal signal path
// R2: Thermal signal held throttles via window, maximum
// R3: Thermal release stops throttle, clears window counters
// R4: Thermal signal ignored outside mode 01
// R5: Mode 10 enables global window counter throttling
// R6: Threshold reached starts counter throttle cycles; the code starts them only when the window count is above the threshold
// R7: Software start bit one throttles until cleared
// R8: Start bit cleared stops, clears window counters
// R9: Software drives start bit to start, stop
// R10: Read control 64-bit at 58h, resets zero, lockable
// R11: Read window is field times sample unit
// R12: Count read hexwords within each global window
// R13: Reads above threshold raise read throttle request
// R14: Read threshold is field times 32K hexwords
// R15: Mode 00 disables counter and thermal paths
// R16: Monitor window field padded; block at maximum
// R17: Counter throttle lasts duration field windows
// R18: Throttle active when any enabled source asks
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module dram_bandwidth_throttle
  import throttle_pkg::*;
#(
  parameter int SAMPLE_UNIT = SAMPLE_UNIT_CLKS,
  parameter int HEX_UNIT = HEXWORD_UNIT
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic wr_limit_hot_in,
  input wire logic wr_hexword,
  input wire logic rd_hexword,
  output logic wr_limit_active,
  output logic wr_block,
  output logic rd_limit_request
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic reg_sel_t reg_sel(input logic [7:0] a);
    reg_sel_t s;
    s = SEL_NONE;
    unique case (a)
      OFF_WCTL_LO: begin
        s = SEL_WLO;
      end
      OFF_WCTL_HI: begin
        s = SEL_WHI;
      end
      OFF_RCTL_LO: begin
        s = SEL_RLO;
      end
      OFF_RCTL_HI: begin
        s = SEL_RHI;
      end
      OFF_STAT: begin
        s = SEL_STAT;
      end
      OFF_LOCK: begin
        s = SEL_LOCK;
      end
      default: begin
        s = SEL_NONE;
      end
    endcase
    return s;
  endfunction

  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] d,
    input logic [3:0] be
  );
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[8*i +: 8] = d[8*i +: 8];
      end
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  state_t r;
  state_t n;

  logic [1:0] wmode;
  logic [31:0] wlen;
  logic [31:0] wthr;
  logic [31:0] wg_sum;
  logic wg_end;
  logic hw_req;
  logic [10:0] mlen;
  logic [31:0] rlen;
  logic [31:0] rthr;
  logic [31:0] rg_sum;
  logic [31:0] stat;
  reg_sel_t wsel;

  assign wmode = r.wctl[MODE_MSB:MODE_LSB];
  assign wlen = 32'(r.wctl[GSW_MSB:GSW_LSB]) * 32'(SAMPLE_UNIT);
  assign wthr = 32'(r.wctl[GHT_MSB:GHT_LSB]) * 32'(HEX_UNIT);
  assign wg_sum = r.wg_hex + {31'h0, wr_hexword};
  assign wg_end = (wlen != 32'h0) && (r.wg_cnt >= wlen - 32'h1);
  assign mlen = {r.wctl[MW_MSB:MW_LSB], 4'h0}; // R16
  assign rlen = 32'(r.rctl[GSW_MSB:GSW_LSB]) * 32'(SAMPLE_UNIT); // R11
  assign rthr = 32'(r.rctl[GHT_MSB:GHT_LSB]) * 32'(HEX_UNIT); // R14
  assign rg_sum = r.rg_hex + {31'h0, rd_hexword};
  assign wsel = reg_sel(r.awaddr);

  // Only the second synchroniser stage is looked at
  assign hw_req = (wmode == MODE_HW) && r.hot_s2; // R1 R4 R15

  assign stat = {18'h0, r.wdur, 2'h0, r.lock, r.hot_s2, r.rover,
                 (r.wdur != 6'h0), r.wblk, r.wact};

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    n = r;
    n.hot_s1 = wr_limit_hot_in;
    n.hot_s2 = r.hot_s1;

    // Register write channel: address and data taken in either order
    if (r.awready && awvalid) begin
      n.aw_hold = 1'b1;
      n.awaddr = awaddr;
    end
    if (r.wready && wvalid) begin
      n.w_hold = 1'b1;
      n.wdata = wdata;
      n.wstrb = wstrb;
    end
    if (r.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    if (r.aw_hold && r.w_hold && !r.bvalid) begin
      n.aw_hold = 1'b0;
      n.w_hold = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      // Lock freezes both controls until reset
      if (r.lock && (wsel inside {SEL_WLO, SEL_WHI, SEL_RLO, SEL_RHI})) begin
        n.bresp = RESP_SLVERR; // R10
      end else begin
        unique case (wsel)
          SEL_WLO: begin
            n.wctl[31:0] = merge(r.wctl[31:0], r.wdata, r.wstrb) & CTL_MASK[31:0]; // R9
          end
          SEL_WHI: begin
            n.wctl[63:32] = merge(r.wctl[63:32], r.wdata, r.wstrb) & CTL_MASK[63:32];
          end
          SEL_RLO: begin
            n.rctl[31:0] = merge(r.rctl[31:0], r.wdata, r.wstrb) & CTL_MASK[31:0]; // R10
          end
          SEL_RHI: begin
            n.rctl[63:32] = merge(r.rctl[63:32], r.wdata, r.wstrb) & CTL_MASK[63:32]; // R10
          end
          SEL_LOCK: begin
            if (r.wstrb[0] && r.wdata[0]) begin
              n.lock = 1'b1; // R10
            end
          end
          SEL_STAT: begin
            n.bresp = RESP_SLVERR;
          end
          SEL_NONE: begin
            n.bresp = RESP_SLVERR;
          end
        endcase
      end
    end

    // Register read channel
    if (r.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    if (r.arready && arvalid) begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      unique case (reg_sel(araddr))
        SEL_WLO: begin
          n.rdata = r.wctl[31:0];
        end
        SEL_WHI: begin
          n.rdata = r.wctl[63:32];
        end
        SEL_RLO: begin
          n.rdata = r.rctl[31:0];
        end
        SEL_RHI: begin
          n.rdata = r.rctl[63:32];
        end
        SEL_STAT: begin
          n.rdata = stat;
        end
        SEL_LOCK: begin
          n.rdata = {31'h0, r.lock};
        end
        SEL_NONE: begin
          n.rdata = 32'h0;
          n.rresp = RESP_SLVERR;
        end
      endcase
    end

    // Readies registered so that every output comes from a flop
    n.awready = !n.aw_hold && !n.bvalid;
    n.wready = !n.w_hold && !n.bvalid;
    n.arready = !n.rvalid;

    // Global write sampling window, counter mode only
    if (wmode != MODE_CNT) begin
      n.wg_cnt = 32'h0; // R15
      n.wg_hex = 32'h0;
      n.wdur = 6'h0;
    end else if (wlen == 32'h0) begin
      n.wg_cnt = 32'h0;
      n.wg_hex = 32'h0;
    end else if (wg_end) begin
      n.wg_cnt = 32'h0;
      n.wg_hex = 32'h0;
      // No retrigger while a throttle period is still running
      if (r.wdur != 6'h0) begin
        n.wdur = r.wdur - 6'h1; // R17
      end else if (wg_sum > wthr) begin
        n.wdur = r.wctl[DUR_MSB:DUR_LSB]; // R5 R6 R17
      end
    end else begin
      n.wg_cnt = r.wg_cnt + 32'h1;
      n.wg_hex = wg_sum;
    end

    // Any enabled source throttles
    n.wact = r.wctl[SW_START_BIT] || hw_req || (r.wdur != 6'h0); // R18 R7 R2 R6

    // Monitoring window cleared whenever throttling stops
    if (!n.wact) begin
      n.wm_cnt = 11'h0; // R3 R8
      n.wm_hex = 12'h0; // R3 R8
    end else if ((mlen == 11'h0) || (r.wm_cnt >= mlen - 11'h1)) begin
      n.wm_cnt = 11'h0; // R16
      n.wm_hex = {11'h0, wr_hexword};
    end else begin
      n.wm_cnt = r.wm_cnt + 11'h1;
      if (wr_hexword && (r.wm_hex != 12'hfff)) begin
        n.wm_hex = r.wm_hex + 12'h1;
      end
    end

    // Block for the rest of the window once the maximum is reached
    n.wblk = n.wact && (n.wm_hex >= r.wctl[HM_MSB:HM_LSB]); // R2 R16

    // Global read sampling window
    if (rlen == 32'h0) begin
      n.rg_cnt = 32'h0;
      n.rg_hex = 32'h0;
      n.rover = 1'b0;
    end else if (r.rg_cnt >= rlen - 32'h1) begin
      n.rg_cnt = 32'h0;
      n.rg_hex = 32'h0;
      n.rover = rg_sum > rthr; // R13
    end else begin
      n.rg_cnt = r.rg_cnt + 32'h1;
      n.rg_hex = rg_sum; // R12
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.wctl <= CTL_RESET;
      r.rctl <= CTL_RESET; // R10
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign awready = r.awready;
  assign wready = r.wready;
  assign bvalid = r.bvalid;
  assign bresp = r.bresp;
  assign arready = r.arready;
  assign rvalid = r.rvalid;
  assign rdata = r.rdata;
  assign rresp = r.rresp;
  assign wr_limit_active = r.wact;
  assign wr_block = r.wblk;
  assign rd_limit_request = r.rover;

endmodule // dram_bandwidth_throttle

`default_nettype wire

/* File: verification/dram_bandwidth_throttle_chk.sv */
// Purpose: Port checks for the bandwidth throttle
// Assumes: Address and data of a write are offered together
// Notes: Mode and start bit mirrored from accepted writes
`timescale 1ns/1ps
`default_nettype none
module thr_chk
  import throttle_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic wr_limit_hot_in,
  input wire logic wr_limit_active,
  input wire logic wr_block
);
  logic [2:0] ctl_r;
  logic [2:0] ctl_nxt;
  logic wtake;
  logic hw_sel;
  assign wtake = awvalid && awready && wvalid && wready;
  assign ctl_nxt = (wtake && awaddr == OFF_WCTL_LO) ? wdata[2:0] : ctl_r;
  assign hw_sel = (ctl_r == 3'h2);
  // Mirror leads the real register by one edge, so repetitions carry a spare cycle
  always_ff @(posedge aclk) begin
    ctl_r <= aresetn ? ctl_nxt : 3'h0;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////
  a_block_active: assert property (wr_block |-> wr_limit_active)
    else $error("block while idle");
  a_hot_on: assert property ((hw_sel && wr_limit_hot_in) [*4] |=> wr_limit_active)
    else $error("hot pin ignored");
  a_hot_off: assert property ((hw_sel && !wr_limit_hot_in) [*4] |=> !wr_limit_active)
    else $error("throttle after hot release");
  a_off_quiet: assert property ((ctl_r == 3'h0) [*4] |=> !wr_limit_active)
    else $error("throttle while disabled");
  a_sw_on: assert property (ctl_r[0] [*3] |=> wr_limit_active)
    else $error("start bit ignored");
  a_write_resp: assert property (wtake |-> ##2 bvalid)
    else $error("late write response");
  a_read_resp: assert property (arvalid && arready |=> rvalid)
    else $error("late read data");
  a_b_drop: assert property (bvalid && bready |=> !bvalid)
    else $error("write response held");
  a_r_drop: assert property (rvalid && rready |=> !rvalid)
    else $error("read data held");
  c_hot: cover property (hw_sel && wr_limit_active);
  c_sw_block: cover property (ctl_r[0] && wr_block);
  c_counter: cover property (ctl_r == 3'h4 && wr_limit_active);
endmodule // thr_chk

bind dram_bandwidth_throttle thr_chk chk_u (.aclk, .aresetn, .awaddr, .awvalid, .awready,
  .wdata, .wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .rready,
  .wr_limit_hot_in, .wr_limit_active, .wr_block);
`default_nettype wire

/* File: verification/sched_model.sv */
// Purpose: Thermal sensor and request scheduler stand-in
// Assumes: One hexword a cycle offered while enabled
// Notes: Pins change on clock edges only
`timescale 1ns/1ps
`default_nettype none
module sched_model (
  input wire logic aclk,
  input wire logic hot_cmd,
  input wire logic wr_go,
  input wire logic rd_go,
  input wire logic wr_block,
  output logic wr_limit_hot_in,
  output logic wr_hexword,
  output logic rd_hexword
);
  initial {wr_limit_hot_in, wr_hexword, rd_hexword} = 3'h0;
  always @(posedge aclk) begin
    wr_limit_hot_in <= hot_cmd;
    wr_hexword <= wr_go && !wr_block;
    rd_hexword <= rd_go;
  end
endmodule // sched_model
`default_nettype wire

/* File: verification/dram_bandwidth_throttle_bench.sv */
// Purpose: Self-checking bench for the bandwidth throttle
// Assumes: Window unit 10 clocks, threshold unit 2 hexwords
// Notes: Register rows first, throttle paths after
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module dram_bandwidth_throttle_bench
  import throttle_pkg::*;
;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, hot_cmd, wr_go, rd_go;
  logic awready, wready, bvalid, arready, rvalid, wr_limit_hot_in, wr_hexword, rd_hexword;
  logic wr_limit_active, wr_block, rd_limit_request;
  logic [1:0] bresp, rresp;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  int num_errors, checks, n, cnt;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d, q;
    logic [1:0] bq, rq;
  } row_t;
  row_t rows [5] = '{
    '{8'h58, 32'hffff_ffff, 32'hffff_ffff, RESP_OKAY, RESP_OKAY},
    '{8'h5c, 32'hffff_ffff, 32'h0001_ffff, RESP_OKAY, RESP_OKAY},
    '{8'h54, 32'h0000_1234, 32'h0000_1234, RESP_OKAY, RESP_OKAY},
    '{8'h60, 32'h0000_00ff, 32'h0000_0000, RESP_SLVERR, RESP_OKAY},
    '{8'h6c, 32'h1234_5678, 32'h0000_0000, RESP_SLVERR, RESP_SLVERR}};
  ////////////////////////////////////////////////////////////////
  dram_bandwidth_throttle #(.SAMPLE_UNIT(10), .HEX_UNIT(2)) dut_u (.aclk, .aresetn, .awaddr,
    .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .wr_limit_hot_in, .wr_hexword, .rd_hexword, .wr_limit_active, .wr_block, .rd_limit_request);
  sched_model sched_u (.aclk, .hot_cmd, .wr_go, .rd_go, .wr_block, .wr_limit_hot_in,
    .wr_hexword, .rd_hexword);
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("errors=%0d checks=%0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 50) begin num_errors++; conclude(); end
    `CHK(bresp, er)
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] eq, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (n == 50) begin num_errors++; conclude(); end
    `CHK(rdata, eq)
    `CHK(rresp, er)
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, hot_cmd, wr_go, rd_go} = '0;
    {awaddr, araddr, wdata} = '0;
    {num_errors, checks} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h58, 32'h0, RESP_OKAY);
    rd(8'h5c, 32'h0, RESP_OKAY);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, rows[i].bq);
      rd(rows[i].a, rows[i].q, rows[i].rq);
    end
    // Hot pin first with the mode off, then with the signal path on
    hot_cmd <= 1'b1;
    repeat (6) @(posedge aclk);
    rd(8'h60, 32'h10, RESP_OKAY);
    wr(8'h50, 32'h2, RESP_OKAY);
    repeat (6) @(posedge aclk);
    rd(8'h60, 32'h13, RESP_OKAY);
    hot_cmd <= 1'b0;
    repeat (6) @(posedge aclk);
    rd(8'h60, 32'h0, RESP_OKAY);
    // Start bit, 16-clock windows of two hexwords against a greedy scheduler
    wr_go <= 1'b1;
    wr(8'h50, 32'h0000_8011, RESP_OKAY);
    cnt = 0;
    repeat (160) begin @(posedge aclk); cnt += wr_hexword; end
    `CHK(cnt inside {[16:34]}, 1'b1)
    `CHK(wr_limit_active, 1'b1)
    wr(8'h50, 32'h0, RESP_OKAY);
    repeat (4) @(posedge aclk);
    `CHK({wr_limit_active, wr_block}, 2'b00)
    // Counter mode: window 10, threshold 2, period of two windows
    wr(8'h54, 32'h0000_0200, RESP_OKAY);
    wr(8'h50, 32'h1080_0004, RESP_OKAY);
    for (n = 0; n < 40 && !wr_limit_active; n++) @(posedge aclk);
    `CHK(wr_limit_active, 1'b1)
    wr_go <= 1'b0;
    for (cnt = 0; cnt < 90 && wr_limit_active; cnt++) @(posedge aclk);
    `CHK(cnt inside {[18:22]}, 1'b1)
    wr(8'h50, 32'h0, RESP_OKAY);
    // Read window of 10 clocks holds exactly 10 hexwords
    wr(8'h5c, 32'h0000_0200, RESP_OKAY);
    wr(8'h58, 32'h1000_0000, RESP_OKAY);
    rd_go <= 1'b1;
    repeat (25) @(posedge aclk);
    `CHK(rd_limit_request, 1'b1)
    wr(8'h58, 32'h5000_0000, RESP_OKAY);
    repeat (30) @(posedge aclk);
    `CHK(rd_limit_request, 1'b0)
    wr(8'h64, 32'h1, RESP_OKAY);
    wr(8'h58, 32'h0, RESP_SLVERR);
    rd(8'h58, 32'h5000_0000, RESP_OKAY);
    // Mid-run reset clears the controls and the lock
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h58, 32'h0, RESP_OKAY);
    wr(8'h58, 32'h1000_0000, RESP_OKAY);
    conclude();
  end
endmodule // dram_bandwidth_throttle_bench
`default_nettype wire
